// *** rtl/rse_exec.sv ***
// rse_exec: executes the rotate, set-bit, short jump, subtract with
// borrow, nibble swap and exchange group of an 8-bit core.
// assumes fetch presents whole instructions, pc_cur holds the address
// of the instruction while it runs, and ram answers one cycle after a read.
`timescale 1ns/100ps
`default_nettype none
module rse_exec (
    // clock and reset
    input  wire logic                 mclk,
    input  wire logic                 rst,
    // instruction from fetch
    input  wire logic                 instr_valid,
    output logic                      instr_ready,
    input  wire rse_pkg::rse_instr_s  instr,
    input  wire logic [15:0]          pc_cur,
    input  wire logic [1:0]           rbank,
    // architectural state
    output logic [7:0]                acc,
    output rse_pkg::rse_flags_s       flags,
    // internal ram
    output rse_pkg::rse_ram_req_s     ram_req,
    input  wire logic [7:0]           ram_rd_data,
    // bit space and program counter
    output logic                      bit_wr_en,
    output logic [7:0]                bit_addr,
    output logic                      pc_load,
    output logic [15:0]               pc_target,
    output logic                      exec_done
);

    rse_pkg::rse_state_e   state_r, state_nxt;
    rse_pkg::rse_op_e      op_r, op_nxt, dec_op;
    rse_pkg::rse_mode_e    dec_mode;
    logic [7:0]            acc_r, acc_nxt;
    rse_pkg::rse_flags_s   flags_r, flags_nxt;
    rse_pkg::rse_ram_req_s ram_req_r, ram_req_nxt;
    logic                  bit_wr_r, bit_wr_nxt;
    logic [7:0]            bit_addr_r, bit_addr_nxt;
    logic                  pc_load_r, pc_load_nxt;
    logic [15:0]           pc_target_r, pc_target_nxt;
    logic                  done_r, done_nxt;
    logic [7:0]            reg_addr_w, ptr_addr_w;
    logic [7:0]            sub_b_w, sub_diff_w, rot_acc_w;
    rse_pkg::rse_flags_s   sub_flags_w;
    logic                  rot_cy_w;
    logic                  accept_w;

    // ready only while no instruction is in flight
    assign instr_ready = (state_r == rse_pkg::S_IDLE);
    assign accept_w    = instr_valid && instr_ready;

    // register-bank addresses for Rn and the Ri pointer
    assign reg_addr_w = {3'h0, rbank, instr.opcode[2:0]};
    assign ptr_addr_w = {3'h0, rbank, 2'h0, instr.opcode[0]};

    // classify the opcode into operation and addressing mode
    always_comb begin
        dec_op   = rse_pkg::OP_NONE;
        dec_mode = rse_pkg::M_NONE;
        if (instr.opcode == rse_pkg::OPC_ROT_RIGHT) begin
            dec_op = rse_pkg::OP_ROTR;
        end else if (instr.opcode == rse_pkg::OPC_ROT_RIGHT_CY) begin
            dec_op = rse_pkg::OP_ROTRC;
        end else if (instr.opcode == rse_pkg::OPC_SET_CARRY) begin
            dec_op = rse_pkg::OP_SETC;
        end else if (instr.opcode == rse_pkg::OPC_SET_BIT) begin
            dec_op = rse_pkg::OP_SET_BIT_OP;
        end else if (instr.opcode == rse_pkg::OPC_SHORT_JUMP) begin
            dec_op = rse_pkg::OP_SHORT_RELATIVE_JUMP;
        end else if (instr.opcode == rse_pkg::OPC_NIBBLE_SWAP) begin
            dec_op = rse_pkg::OP_SWAP;
        end else if (instr.opcode == rse_pkg::OPC_SUB_DIRECT) begin
            dec_op   = rse_pkg::OP_SUBTRACT_WITH_BORROW;
            dec_mode = rse_pkg::M_DIR;
        end else if (instr.opcode == rse_pkg::OPC_SUB_IMMED) begin
            dec_op   = rse_pkg::OP_SUBTRACT_WITH_BORROW;
            dec_mode = rse_pkg::M_IMM;
        end else if (instr.opcode[7:1] == rse_pkg::OPC_SUB_INDIR_HI) begin
            dec_op   = rse_pkg::OP_SUBTRACT_WITH_BORROW;
            dec_mode = rse_pkg::M_IND;
        end else if (instr.opcode[7:3] == rse_pkg::OPC_SUB_REG_HI) begin
            dec_op   = rse_pkg::OP_SUBTRACT_WITH_BORROW;
            dec_mode = rse_pkg::M_REG;
        end else if (instr.opcode[7:3] == rse_pkg::OPC_XCH_REG_HI) begin
            dec_op   = rse_pkg::OP_XCH;
            dec_mode = rse_pkg::M_REG;
        end else if (instr.opcode == rse_pkg::OPC_XCH_DIRECT) begin
            dec_op   = rse_pkg::OP_XCH;
            dec_mode = rse_pkg::M_DIR;
        end else if (instr.opcode[7:1] == rse_pkg::OPC_XCH_INDIR_HI) begin
            dec_op   = rse_pkg::OP_XCH;
            dec_mode = rse_pkg::M_IND;
        end
    end

    // subtract source: fetched byte, or immediate data byte
    assign sub_b_w = (state_r == rse_pkg::S_OPN_DAT) ? ram_rd_data
                                                     : instr.operand;

    // borrow subtractor
    rse_sub_borrow #(
        .W      (rse_pkg::DATA_W)
    ) u_sub (
        .a      (acc_r),
        .b      (sub_b_w),
        .cin    (flags_r.cy),
        .diff   (sub_diff_w),
        .flags  (sub_flags_w)
    );

    // rotate and swap unit
    rse_rotate_unit u_rot (
        .acc_in  (acc_r),
        .cy_in   (flags_r.cy),
        .op      (dec_op),
        .acc_out (rot_acc_w),
        .cy_out  (rot_cy_w)
    );

    // sequencer next state and datapath next values
    always_comb begin
        state_nxt     = state_r;
        op_nxt        = op_r;
        acc_nxt       = acc_r;
        flags_nxt     = flags_r;
        ram_req_nxt   = ram_req_r;
        ram_req_nxt.rd_en = 1'b0;
        ram_req_nxt.wr_en = 1'b0;
        bit_wr_nxt    = 1'b0;
        bit_addr_nxt  = bit_addr_r;
        pc_load_nxt   = 1'b0;
        pc_target_nxt = pc_target_r;
        done_nxt      = 1'b0;
        case (state_r)
            rse_pkg::S_IDLE: begin
                if (accept_w) begin
                    op_nxt = dec_op;
                    case (dec_op)
                        rse_pkg::OP_ROTR, rse_pkg::OP_SWAP: begin
                            acc_nxt  = rot_acc_w;
                            done_nxt = 1'b1;
                        end
                        rse_pkg::OP_ROTRC: begin
                            acc_nxt      = rot_acc_w;
                            flags_nxt.cy = rot_cy_w;
                            done_nxt     = 1'b1;
                        end
                        rse_pkg::OP_SETC: begin
                            flags_nxt.cy = 1'b1;
                            done_nxt     = 1'b1;
                        end
                        rse_pkg::OP_SET_BIT_OP: begin
                            bit_wr_nxt   = 1'b1;
                            bit_addr_nxt = instr.operand;
                            done_nxt     = 1'b1;
                        end
                        rse_pkg::OP_SHORT_RELATIVE_JUMP: begin
                            pc_target_nxt = pc_cur + rse_pkg::JUMP_LEN
                                + {{8{instr.operand[7]}}, instr.operand};
                            state_nxt     = rse_pkg::S_JMP;
                        end
                        rse_pkg::OP_SUBTRACT_WITH_BORROW, rse_pkg::OP_XCH: begin
                            case (dec_mode)
                                rse_pkg::M_IMM: begin
                                    acc_nxt   = sub_diff_w;
                                    flags_nxt = sub_flags_w;
                                    done_nxt  = 1'b1;
                                end
                                rse_pkg::M_REG: begin
                                    ram_req_nxt.rd_en = 1'b1;
                                    ram_req_nxt.addr  = reg_addr_w;
                                    state_nxt = rse_pkg::S_OPN_ADR;
                                end
                                rse_pkg::M_DIR: begin
                                    ram_req_nxt.rd_en = 1'b1;
                                    ram_req_nxt.addr  = instr.operand;
                                    state_nxt = rse_pkg::S_OPN_ADR;
                                end
                                rse_pkg::M_IND: begin
                                    ram_req_nxt.rd_en = 1'b1;
                                    ram_req_nxt.addr  = ptr_addr_w;
                                    state_nxt = rse_pkg::S_PTR_ADR;
                                end
                                default: begin
                                    done_nxt = 1'b1;
                                end
                            endcase
                        end
                        default: begin
                            done_nxt = 1'b1;                          // unknown opcode: no effect
                        end
                    endcase
                end
            end
            rse_pkg::S_PTR_ADR: begin
                state_nxt = rse_pkg::S_PTR_DAT;                       // ram sees pointer read
            end
            rse_pkg::S_PTR_DAT: begin
                ram_req_nxt.rd_en = 1'b1;
                ram_req_nxt.addr  = ram_rd_data;
                state_nxt         = rse_pkg::S_OPN_ADR;
            end
            rse_pkg::S_OPN_ADR: begin
                state_nxt = rse_pkg::S_OPN_DAT;                       // ram sees operand read
            end
            rse_pkg::S_OPN_DAT: begin
                if (op_r == rse_pkg::OP_XCH) begin
                    acc_nxt             = ram_rd_data;
                    ram_req_nxt.wr_en   = 1'b1;
                    ram_req_nxt.wr_data = acc_r;
                end else begin
                    acc_nxt   = sub_diff_w;
                    flags_nxt = sub_flags_w;
                end
                done_nxt  = 1'b1;
                state_nxt = rse_pkg::S_IDLE;
            end
            rse_pkg::S_JMP: begin
                pc_load_nxt = 1'b1;
                done_nxt    = 1'b1;
                state_nxt   = rse_pkg::S_IDLE;
            end
            default: begin
                state_nxt = rse_pkg::S_IDLE;
            end
        endcase
    end

    // register sequencer and datapath state
    always_ff @(posedge mclk) begin
        if (rst) begin
            state_r     <= rse_pkg::S_IDLE;
            op_r        <= rse_pkg::OP_NONE;
            acc_r       <= rse_pkg::ACC_RST;
            flags_r     <= '0;
            ram_req_r   <= '0;
            bit_wr_r    <= 1'b0;
            bit_addr_r  <= 8'h00;
            pc_load_r   <= 1'b0;
            pc_target_r <= 16'h0000;
            done_r      <= 1'b0;
        end else begin
            state_r     <= state_nxt;
            op_r        <= op_nxt;
            acc_r       <= acc_nxt;
            flags_r     <= flags_nxt;
            ram_req_r   <= ram_req_nxt;
            bit_wr_r    <= bit_wr_nxt;
            bit_addr_r  <= bit_addr_nxt;
            pc_load_r   <= pc_load_nxt;
            pc_target_r <= pc_target_nxt;
            done_r      <= done_nxt;
        end
    end

    // registered outputs
    assign acc       = acc_r;
    assign flags     = flags_r;
    assign ram_req   = ram_req_r;
    assign bit_wr_en = bit_wr_r;
    assign bit_addr  = bit_addr_r;
    assign pc_load   = pc_load_r;
    assign pc_target = pc_target_r;
    assign exec_done = done_r;

endmodule : rse_exec
`default_nettype wire

// *** rtl/rse_pkg.sv ***
// rse_pkg: shared constants, carriers and enums for the rotate,
// subtract and exchange execution group.
// assumes an 8-bit accumulator core with 16-bit program counter.
package rse_pkg;

    // datapath widths
    localparam int DATA_W = 8;
    localparam int PC_W   = 16;
    localparam int NIB_W  = 4;

    // one-byte and first-byte opcodes
    localparam logic [7:0] OPC_ROT_RIGHT      = 8'h03;
    localparam logic [7:0] OPC_ROT_RIGHT_CY   = 8'h13;
    localparam logic [7:0] OPC_SET_CARRY      = 8'hd3;
    localparam logic [7:0] OPC_SET_BIT        = 8'hd2;
    localparam logic [7:0] OPC_SHORT_JUMP     = 8'h80;
    localparam logic [7:0] OPC_SUB_DIRECT     = 8'h95;
    localparam logic [7:0] OPC_SUB_IMMED      = 8'h94;
    localparam logic [6:0] OPC_SUB_INDIR_HI   = 7'h4b;
    localparam logic [4:0] OPC_SUB_REG_HI     = 5'h13;
    localparam logic [7:0] OPC_NIBBLE_SWAP    = 8'hc4;
    localparam logic [4:0] OPC_XCH_REG_HI     = 5'h19;
    localparam logic [7:0] OPC_XCH_DIRECT     = 8'hc5;
    localparam logic [6:0] OPC_XCH_INDIR_HI   = 7'h63;

    // short jump advances the counter by the instruction length first
    localparam logic [15:0] JUMP_LEN = 16'h0002;

    // reset values
    localparam logic [7:0] ACC_RST = 8'h00;

    // ram address layout: bank in bits 4-3, register in bits 2-0
    localparam int REG_SEL_W = 3;
    localparam int BANK_W    = 2;

    typedef struct packed {
        logic [7:0] opcode;
        logic [7:0] operand;   // second byte, ignored by one-byte forms
    } rse_instr_s;

    typedef struct packed {
        logic cy;
        logic ac;
        logic ov;
    } rse_flags_s;

    typedef struct packed {
        logic       rd_en;
        logic       wr_en;
        logic [7:0] addr;
        logic [7:0] wr_data;
    } rse_ram_req_s;

    typedef enum logic [3:0] {
        OP_NONE, OP_ROTR, OP_ROTRC, OP_SETC, OP_SET_BIT_OP,
        OP_SHORT_RELATIVE_JUMP, OP_SUBTRACT_WITH_BORROW, OP_XCH, OP_SWAP
    } rse_op_e;

    typedef enum logic [2:0] {
        M_NONE, M_REG, M_DIR, M_IND, M_IMM
    } rse_mode_e;

    typedef enum logic [2:0] {
        S_IDLE, S_PTR_ADR, S_PTR_DAT, S_OPN_ADR, S_OPN_DAT, S_JMP
    } rse_state_e;

endpackage : rse_pkg

// *** rtl/rse_rotate_unit.sv ***
// rse_rotate_unit: accumulator rotate-right, rotate through carry and
// nibble swap, purely combinational.
// assumes the caller registers the result and owns the carry flag.
`timescale 1ns/100ps
`default_nettype none
module rse_rotate_unit (
    // operands
    input  wire logic [7:0]     acc_in,
    input  wire logic           cy_in,
    input  wire rse_pkg::rse_op_e op,
    // results
    output logic [7:0]          acc_out,
    output logic                cy_out
);

    // select shifted accumulator; carry passes unless rotate through carry
    always_comb begin
        acc_out = acc_in;
        cy_out  = cy_in;
        case (op)
            rse_pkg::OP_ROTR: begin
                acc_out = {acc_in[0], acc_in[7:1]};
            end
            rse_pkg::OP_ROTRC: begin
                acc_out = {cy_in, acc_in[7:1]};
                cy_out  = acc_in[0];
            end
            rse_pkg::OP_SWAP: begin
                acc_out = {acc_in[3:0], acc_in[7:4]};
            end
            default: begin
                acc_out = acc_in;
                cy_out  = cy_in;
            end
        endcase
    end

endmodule : rse_rotate_unit
`default_nettype wire

// *** rtl/rse_sub_borrow.sv ***
// rse_sub_borrow: accumulator minus carry minus operand with borrow
// flags for bits 3, 6 and 7.
// assumes byte operands; combinational.
`timescale 1ns/100ps
`default_nettype none
module rse_sub_borrow #(
    parameter int W = 8
) (
    // operands
    input  wire logic [W-1:0]     a,
    input  wire logic [W-1:0]     b,
    input  wire logic             cin,
    // results
    output logic [W-1:0]          diff,
    output rse_pkg::rse_flags_s   flags
);

    // elaboration check: flag taps need a full byte
    if (W != 8) begin : g_chk
        $error("rse_sub_borrow supports W = 8 only");
    end

    logic [W:0]   full_w;
    logic [4:0]   low_w;
    logic [7:0]   b6_w;

    // three borrow chains sharing one carry-in
    always_comb begin
        full_w = {1'b0, a} - {1'b0, b} - {{W{1'b0}}, cin};
        low_w  = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cin};
        b6_w   = {1'b0, a[6:0]} - {1'b0, b[6:0]} - {7'h00, cin};
        diff     = full_w[W-1:0];
        flags.cy = full_w[W];
        flags.ac = low_w[4];
        flags.ov = b6_w[7] ^ full_w[W];
    end

endmodule : rse_sub_borrow
`default_nettype wire

// *** verification/rse_exec_props.sv ***
// rse_exec_props: port-level assertions for the rotate, subtract and exchange group.
// assumes it is bound to rse_exec and sees only that module's ports.
`timescale 1ns/100ps
`default_nettype none
module rse_exec_props (
    // clock and reset
    input wire logic                  mclk,
    input wire logic                  rst,
    // fetch side
    input wire logic                  instr_valid,
    input wire logic                  instr_ready,
    input wire rse_pkg::rse_instr_s   instr,
    input wire logic [15:0]           pc_cur,
    input wire logic [1:0]            rbank,
    // state and outputs
    input wire logic [7:0]            acc,
    input wire rse_pkg::rse_flags_s   flags,
    input wire rse_pkg::rse_ram_req_s ram_req,
    input wire logic [7:0]            ram_rd_data,
    input wire logic                  bit_wr_en,
    input wire logic [7:0]            bit_addr,
    input wire logic                  pc_load,
    input wire logic [15:0]           pc_target,
    input wire logic                  exec_done
);
    logic       acpt;
    logic [8:0] ring;

    // reference subtract: {borrow 7, borrow 3, overflow, difference}
    function automatic logic [10:0] sbb(input logic [7:0] a, input logic [7:0] b, input logic c);
        logic [8:0] r;
        logic [4:0] l;
        logic [7:0] m;
        r = {1'b0, a} - {1'b0, b} - {8'h00, c};
        l = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, c};
        m = {1'b0, a[6:0]} - {1'b0, b[6:0]} - {7'h00, c};
        return {r[8], l[4], r[8] ^ m[7], r[7:0]};
    endfunction : sbb

    // accept strobe and the nine-bit carry ring
    assign acpt = instr_valid && instr_ready;
    assign ring = {flags.cy, acc};

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    chk_rot_right: assert property (
        acpt && instr.opcode == rse_pkg::OPC_ROT_RIGHT |=> exec_done
        && acc == 8'({$past(acc), $past(acc)} >> 1) && flags == $past(flags))
        else $error("rotate right result wrong");
    chk_rot_carry: assert property (
        acpt && instr.opcode == rse_pkg::OPC_ROT_RIGHT_CY |=> acc == 8'($past(ring) >> 1)
        && flags.cy == 1'($past(acc)) && {flags.ac, flags.ov} == 2'($past(flags)))
        else $error("rotate through carry result wrong");
    chk_set_carry: assert property (
        acpt && instr.opcode == rse_pkg::OPC_SET_CARRY |=> exec_done
        && flags == ($past(flags) | 3'b100) && !bit_wr_en)
        else $error("set carry result wrong");
    chk_set_bit: assert property (
        acpt && instr.opcode == rse_pkg::OPC_SET_BIT |=> bit_wr_en && exec_done
        && bit_addr == 8'($past(instr)) && flags == $past(flags))
        else $error("set bit write wrong");
    chk_jump_target: assert property (
        acpt && instr.opcode == rse_pkg::OPC_SHORT_JUMP |-> ##1 !exec_done ##1 (exec_done
        && pc_load && pc_target == $past(pc_cur, 2) + 16'h0002 + 16'($signed(8'($past(instr, 2))))))
        else $error("short jump target wrong");
    chk_sub_immed: assert property (
        acpt && instr.opcode == rse_pkg::OPC_SUB_IMMED |=> exec_done
        && {flags, acc} == sbb($past(acc), 8'($past(instr)), 1'($past(flags) >> 2)))
        else $error("subtract immediate result wrong");
    chk_sub_direct: assert property (
        acpt && instr.opcode == rse_pkg::OPC_SUB_DIRECT |-> ##1 (ram_req.rd_en
        && ram_req.addr == 8'($past(instr))) ##2 (exec_done
        && {flags, acc} == sbb($past(acc, 3), $past(ram_rd_data), 1'($past(flags, 3) >> 2))))
        else $error("subtract direct result wrong");
    chk_sub_reg: assert property (
        acpt && instr.opcode[7:3] == rse_pkg::OPC_SUB_REG_HI |=> ram_req.rd_en
        && ram_req.addr == {3'b000, $past(rbank), 3'($past(instr) >> 8)})
        else $error("subtract register address wrong");
    chk_xch_direct: assert property (
        acpt && instr.opcode == rse_pkg::OPC_XCH_DIRECT |-> ##3 (exec_done && ram_req.wr_en
        && ram_req.wr_data == $past(acc, 3) && ram_req.addr == 8'($past(instr, 3))
        && acc == $past(ram_rd_data)))
        else $error("exchange direct wrong");
    chk_xch_ptr: assert property (
        acpt && instr.opcode[7:1] == rse_pkg::OPC_XCH_INDIR_HI |=> ram_req.rd_en
        && ram_req.addr == {3'b000, $past(rbank), 2'b00, 1'($past(instr) >> 8)} ##4 exec_done)
        else $error("exchange indirect pointer wrong");
    chk_swap_nib: assert property (
        acpt && instr.opcode == rse_pkg::OPC_NIBBLE_SWAP |=> exec_done
        && acc == 8'({$past(acc), $past(acc)} >> 4) && flags == $past(flags))
        else $error("nibble swap result wrong");
endmodule : rse_exec_props

bind rse_exec rse_exec_props u_props (.mclk(mclk), .rst(rst), .instr_valid(instr_valid),
    .instr_ready(instr_ready), .instr(instr), .pc_cur(pc_cur), .rbank(rbank), .acc(acc),
    .flags(flags), .ram_req(ram_req), .ram_rd_data(ram_rd_data), .bit_wr_en(bit_wr_en),
    .bit_addr(bit_addr), .pc_load(pc_load), .pc_target(pc_target), .exec_done(exec_done));
`default_nettype wire

// *** verification/rse_exec_tb.sv ***
// rse_exec_tb: self-checking bench for the rotate, subtract and exchange group.
// assumes the bench stands in for fetch and internal ram on one clock.
`timescale 1ns/100ps
`default_nettype none
module rse_exec_tb;
    logic                  mclk = 1'b0;
    logic                  rst;
    logic                  instr_valid;
    logic                  instr_ready;
    rse_pkg::rse_instr_s   instr;
    logic [15:0]           pc_cur;
    logic [1:0]            rbank;
    logic [7:0]            acc;
    rse_pkg::rse_flags_s   flags;
    rse_pkg::rse_ram_req_s ram_req;
    logic [7:0]            ram_rd_data = 8'h00;
    logic                  bit_wr_en;
    logic [7:0]            bit_addr;
    logic                  pc_load;
    logic [15:0]           pc_target;
    logic                  exec_done;
    logic [7:0]            mem [256];
    logic [7:0]            acc_m;
    rse_pkg::rse_flags_s   fl_m;
    logic [31:0]           seed = 32'h0000_0034;
    int                    num_errors = 0;
    int                    n_tests = 0;
    logic [7:0] ops [13] = '{8'h03, 8'h13, 8'hd3, 8'hd2, 8'h80, 8'hc4, 8'h94, 8'h95, 8'h96,
                             8'h98, 8'hc5, 8'hc6, 8'hc8};
    logic [7:0] msk [13] = '{8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h1,
                             8'h7, 8'h0, 8'h1, 8'h7};

    rse_exec uut (.mclk(mclk), .rst(rst), .instr_valid(instr_valid),
        .instr_ready(instr_ready), .instr(instr), .pc_cur(pc_cur), .rbank(rbank), .acc(acc),
        .flags(flags), .ram_req(ram_req), .ram_rd_data(ram_rd_data), .bit_wr_en(bit_wr_en),
        .bit_addr(bit_addr), .pc_load(pc_load), .pc_target(pc_target), .exec_done(exec_done));

    // 250 MHz clock
    always #2 mclk = ~mclk;

    // ram stand-in: answers a read next cycle, scrambles the bus otherwise
    always @(posedge mclk) begin
        if (ram_req.rd_en === 1'b1) ram_rd_data <= #1 mem[ram_req.addr];
        else ram_rd_data <= #1 ~ram_rd_data;
    end

    // xorshift source
    function logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    // reference subtract: {borrow 7, borrow 3, overflow, difference}
    function automatic logic [10:0] sbb(input logic [7:0] a, input logic [7:0] b, input logic c);
        logic [8:0] r;
        logic [4:0] l;
        logic [7:0] m;
        r = {1'b0, a} - {1'b0, b} - {8'h00, c};
        l = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, c};
        m = {1'b0, a[6:0]} - {1'b0, b[6:0]} - {7'h00, c};
        return {r[8], l[4], r[8] ^ m[7], r[7:0]};
    endfunction : sbb

    // comparisons, one per kind of result
    task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_byte

    task automatic chk_word(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_word

    task automatic chk_flags(input string what, input rse_pkg::rse_flags_s exp,
                             input rse_pkg::rse_flags_s got);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %b seen %b", what, exp, got);
        end
    endtask : chk_flags

    // issue one instruction, predict its effect and check it at completion
    task automatic run_op(input logic [7:0] opc, input logic [7:0] opd, input logic [1:0] bk);
        logic [7:0]          a;
        logic [7:0]          wa;
        logic [7:0]          src;
        logic                wr;
        logic                sub;
        int                  lat;
        int                  n;
        rse_pkg::rse_flags_s f;
        instr = '{opcode: opc, operand: opd};
        instr_valid = 1'b1;
        pc_cur = 16'(rnd());
        rbank = bk;
        a = acc_m;
        f = fl_m;
        wa = opd;
        src = opd;
        wr = 1'b0;
        sub = 1'b0;
        lat = 1;
        casez (opc)
            8'h03: a = {acc_m[0], acc_m[7:1]};
            8'h13: {a, f.cy} = {fl_m.cy, acc_m};
            8'hd3: f.cy = 1'b1;
            8'h80: lat = 2;
            8'hc4: a = {acc_m[3:0], acc_m[7:4]};
            8'h94: sub = 1'b1;
            8'h95, 8'hc5: lat = 3;
            8'b1001_011?, 8'b1100_011?: begin
                lat = 5;
                wa = mem[{3'b000, bk, 2'b00, opc[0]}];
            end
            8'b1001_1???, 8'b1100_1???: begin
                lat = 3;
                wa = {3'b000, bk, opc[2:0]};
            end
            default: ;
        endcase
        if (lat > 2) begin
            src = mem[wa];
            sub = !opc[6];
            wr = opc[6];
        end
        if (sub) {f, a} = sbb(acc_m, src, fl_m.cy);
        if (wr) a = src;
        @(posedge mclk);
        #1 instr_valid = 1'b0;
        n = 1;
        while (exec_done !== 1'b1 && n < 12) begin
            @(posedge mclk);
            #1 n++;
        end
        chk_byte("latency", 8'(lat), 8'(n));
        chk_byte("ready", 8'h01, {7'h00, instr_ready});
        chk_byte("acc", a, acc);
        chk_flags("flags", f, flags);
        chk_byte("bit write", {7'h00, opc == 8'hd2}, {7'h00, bit_wr_en});
        chk_byte("jump load", {7'h00, opc == 8'h80}, {7'h00, pc_load});
        chk_byte("ram write", {7'h00, wr}, {7'h00, ram_req.wr_en});
        if (opc == 8'hd2) chk_byte("bit addr", opd, bit_addr);
        if (opc == 8'h80) begin
            chk_word("target", pc_cur + 16'h0002 + 16'($signed(opd)), pc_target);
        end
        if (wr) begin
            chk_word("write addr data", {wa, acc_m}, {ram_req.addr, ram_req.wr_data});
            mem[wa] = acc_m;
        end
        acc_m = a;
        fl_m = f;
        @(posedge mclk) #1;
    endtask : run_op

    task automatic test_end(input string name);
        $display("test %s done, checks so far %0d", name, n_tests);
    endtask : test_end

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_of_test

    // watchdog
    initial begin
        repeat (20000) @(posedge mclk);
        num_errors++;
        end_of_test();
    end

    // main sequence
    initial begin
        logic [31:0] r;
        int          k;
        rst = 1'b1;
        instr_valid = 1'b0;
        instr = '0;
        pc_cur = 16'h0000;
        rbank = 2'b00;
        acc_m = 8'h00;
        fl_m = '0;
        foreach (mem[i]) mem[i] = 8'(rnd());
        repeat (3) @(posedge mclk);
        #1 rst = 1'b0;
        chk_byte("reset acc", 8'h00, acc);
        chk_flags("reset flags", 3'b000, flags);
        test_end("reset");
        mem[8'h0a] = 8'hc9;
        run_op(8'hca, 8'h00, 2'b01);
        mem[8'h0a] = 8'h54;
        run_op(8'hd3, 8'h00, 2'b01);
        run_op(8'h9a, 8'h00, 2'b01);
        chk_byte("worked acc", 8'h74, acc);
        chk_flags("worked flags", 3'b001, flags);
        test_end("worked subtract");
        for (int i = 0; i < 256; i++) run_op(8'(i), 8'(rnd()), 2'(rnd()));
        test_end("opcode sweep");
        run_op(8'h80, 8'h80, 2'b00);
        run_op(8'h80, 8'h7f, 2'b11);
        test_end("jump range");
        for (int i = 0; i < 300; i++) begin
            r = rnd();
            k = int'(r[3:0]) % 13;
            run_op(ops[k] | (msk[k] & r[15:8]), r[23:16], r[25:24]);
        end
        test_end("random mix");
        rst = 1'b1;
        @(posedge mclk);
        #1 rst = 1'b0;
        acc_m = 8'h00;
        fl_m = '0;
        chk_byte("rerun acc", 8'h00, acc);
        run_op(8'h13, 8'h00, 2'b00);
        run_op(8'h94, 8'h01, 2'b00);
        test_end("second reset");
        end_of_test();
    end
endmodule : rse_exec_tb
`default_nettype wire
